//--- rtl/fiac_pkg.sv
/*
  Constants, register indices, field positions and carrier types for the
  flash in-application programming control block.
  Assumes a 50 MHz core clock and a byte-wide register port.
*/
package fiac_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int ERASE_TIME_STD_NS = 3200000;
	localparam int WRITE_TIME_STD_NS = 2200000;
	localparam int ERASE_TIME_LONG_NS = 3700000;
	localparam int WRITE_TIME_LONG_NS = 3000000;
	localparam int UNLOCK_TIME_NS = 20000;
	localparam int ERASE_STD_CYCLES = ERASE_TIME_STD_NS / CLK_PERIOD_NS;
	localparam int WRITE_STD_CYCLES = WRITE_TIME_STD_NS / CLK_PERIOD_NS;
	localparam int ERASE_LONG_CYCLES = ERASE_TIME_LONG_NS / CLK_PERIOD_NS;
	localparam int WRITE_LONG_CYCLES = WRITE_TIME_LONG_NS / CLK_PERIOD_NS;
	localparam int UNLOCK_CYCLES = UNLOCK_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 24;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_OP_CONTROL = 4'h0;
	localparam logic [3:0] IDX_CHIP_RESET_KEY = 4'h1;
	localparam logic [3:0] IDX_TIMING_BUFFER = 4'h2;
	localparam logic [3:0] IDX_ADDRESS_LOW = 4'h3;
	localparam logic [3:0] IDX_ADDRESS_HIGH = 4'h4;
	localparam logic [3:0] IDX_DATA0_LOW = 4'h5;
	localparam logic [3:0] IDX_DATA0_HIGH = 4'h6;
	localparam logic [3:0] IDX_DATA1_LOW = 4'h7;
	localparam logic [3:0] IDX_DATA1_HIGH = 4'h8;
	localparam logic [3:0] IDX_DATA2_LOW = 4'h9;
	localparam logic [3:0] IDX_DATA2_HIGH = 4'ha;
	localparam logic [3:0] IDX_DATA3_LOW = 4'hb;
	localparam logic [3:0] IDX_DATA3_HIGH = 4'hc;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int OPC_UNLOCK_STATUS = 7;
	localparam int OPC_SELECT_MSB = 6;
	localparam int OPC_SELECT_LSB = 4;
	localparam int OPC_UNLOCK_TRIGGER = 3;
	localparam int OPC_PROGRAM_GO = 2;
	localparam int OPC_READ_PERMIT = 1;
	localparam int OPC_READ_GO = 0;
	localparam int TBC_TIME_SELECT = 1;
	localparam int TBC_BUFFER_CLEAR = 0;
	localparam int ADDR_W = 13;
	localparam int ADDR_HIGH_W = 5;
	localparam int PAGE_OFS_W = 5;
	localparam logic [PAGE_OFS_W-1:0] PAGE_LAST_WORD = 5'h1f;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [2:0] UNUSED_HIGH_ZERO = 3'h0;
	localparam logic [5:0] UNUSED_TBC_ZERO = 6'h00;

	// ----------------------------------------------------------------
	// Operation codes and key values
	// ----------------------------------------------------------------
	localparam logic [2:0] OP_WRITE = 3'h0;
	localparam logic [2:0] OP_PAGE_ERASE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h3;
	localparam logic [2:0] OP_UNLOCK = 3'h6;
	localparam logic [7:0] CHIP_RESET_PATTERN = 8'h55;
	localparam logic [7:0] KEY1_LOW = 8'h00;
	localparam logic [7:0] KEY2_LOW = 8'h0d;
	localparam logic [7:0] KEY3_LOW = 8'hc3;
	localparam logic [7:0] KEY1_HIGH = 8'h04;
	localparam logic [7:0] KEY2_HIGH = 8'h09;
	localparam logic [7:0] KEY3_HIGH = 8'h40;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] index;
		logic [7:0] wdata;
	} fiac_reg_req_type;

	typedef struct packed {
		logic buf_load;
		logic [PAGE_OFS_W-1:0] buf_word;
		logic [15:0] buf_data;
		logic buf_clear;
		logic erase;
		logic write;
		logic read;
		logic [ADDR_W-1:0] addr;
	} fiac_flash_cmd_type;

endpackage

//--- rtl/fiac_timer.sv
/*
  Down-counting duration timer with a one-cycle expiry pulse.
  Assumes load and abort are never raised in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module fiac_timer
	import fiac_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic abort,
	input wire logic [TIMER_W-1:0] load_value,
	// Status
	output var logic busy_reg,
	output var logic expire_reg
);

	logic [TIMER_W-1:0] count_reg;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			busy_reg <= 1'b0;
			expire_reg <= 1'b0;
		end else begin
			expire_reg <= 1'b0;
			if (abort) begin
				count_reg <= '0;
				busy_reg <= 1'b0;
			end else if (load) begin
				count_reg <= load_value;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (count_reg <= TIMER_W'(1)) begin
					busy_reg <= 1'b0;
					expire_reg <= 1'b1;
					count_reg <= '0;
				end else begin
					count_reg <= count_reg - TIMER_W'(1);
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- rtl/fiac_control.sv
/*
  Flash in-application programming control: unlock, erase, write, read,
  write-buffer clear, address auto-increment and whole-chip reset key.
  Assumes one register access per cycle and a flash array that answers a
  read with one valid pulse and holds its write buffer outside this block.
*/
// Behaviour
// - Software clears unlock status; writing one ignored.
// - Only successful unlock sequence sets unlock status.
// - Operation select: write, erase, read, unlock.
// - Unlock trigger starts timer; cleared on expiry.
// - Program go runs erase/write; clears when done.
// - Reads happen only while read permit set.
// - Read go starts read; clears when done.
// - Processor stalled while erase, write or read runs.
// - Writing 55 to reset key resets chip.
// - Time select picks erase and write durations.
// - Buffer clear go clears buffer; self-clears.
// - Unimplemented upper bits read as zero.
// - Word address thirteen bits over two registers.
// - Low data byte write only stores itself.
// - High data byte loads word, increments address; code loads the word only while unlock status set.
// - Data pairs one to three plain readable bytes.
// - Address holds at last word of page.
// - Finished write clears the write buffer.
`timescale 1ns/1ps
`default_nettype none

module fiac_control
	import fiac_pkg::*;
#(
	parameter int ERASE_STD = ERASE_STD_CYCLES,
	parameter int WRITE_STD = WRITE_STD_CYCLES,
	parameter int ERASE_LONG = ERASE_LONG_CYCLES,
	parameter int WRITE_LONG = WRITE_LONG_CYCLES,
	parameter int UNLOCK_LEN = UNLOCK_CYCLES
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire fiac_reg_req_type reg_req,
	output var logic [7:0] reg_rdata_reg,
	// Flash array and write buffer
	output var fiac_flash_cmd_type flash_cmd_reg,
	input wire logic flash_rd_valid,
	input wire logic [15:0] flash_rd_data,
	// System
	output var logic cpu_stall_reg,
	output var logic chip_reset_reg
);

	typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_WRITE, ST_READ, ST_CLEAR} fiac_state_type;

	fiac_state_type state_reg;
	fiac_state_type state_next;
	logic unlock_status_reg;
	logic [2:0] operation_select_reg;
	logic unlock_trigger_reg;
	logic program_go_reg;
	logic read_permit_reg;
	logic read_go_reg;
	logic [7:0] chip_reset_key_reg;
	logic program_time_select_reg;
	logic buffer_clear_go_reg;
	logic [ADDR_W-1:0] address_reg;
	logic [7:0] data_low_reg [4];
	logic [7:0] data_high_reg [4];
	logic wr_op;
	logic wr_key;
	logic wr_tbc;
	logic wr_d0h;
	logic key_match;
	logic unlock_set;
	logic start_prog;
	logic start_read;
	logic start_clear;
	logic prog_done;
	logic prog_busy;
	logic unlock_load;
	logic unlock_busy;
	logic unlock_expire;
	logic [TIMER_W-1:0] prog_len;
	logic [7:0] rd_mux;

	assign wr_op = reg_req.wr && (reg_req.index == IDX_OP_CONTROL);
	assign wr_key = reg_req.wr && (reg_req.index == IDX_CHIP_RESET_KEY);
	assign wr_tbc = reg_req.wr && (reg_req.index == IDX_TIMING_BUFFER);
	assign wr_d0h = reg_req.wr && (reg_req.index == IDX_DATA0_HIGH);

	// ----------------------------------------------------------------
	// Unlock sequence
	// ----------------------------------------------------------------
	assign key_match = (data_low_reg[1] == KEY1_LOW) && (data_low_reg[2] == KEY2_LOW) &&
		(data_low_reg[3] == KEY3_LOW) && (data_high_reg[1] == KEY1_HIGH) &&
		(data_high_reg[2] == KEY2_HIGH) && (data_high_reg[3] == KEY3_HIGH);

	assign unlock_set = unlock_trigger_reg && unlock_busy &&
		(operation_select_reg == OP_UNLOCK) && key_match;

	assign unlock_load = wr_op && reg_req.wdata[OPC_UNLOCK_TRIGGER] && !unlock_trigger_reg;

	fiac_timer u_unlock_timer (
		.core_clk(core_clk),
		.rst(rst),
		.load(unlock_load),
		.abort(1'b0),
		.load_value(TIMER_W'(UNLOCK_LEN)),
		.busy_reg(unlock_busy),
		.expire_reg(unlock_expire)
	);

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	assign start_prog = (state_reg == ST_IDLE) && program_go_reg && unlock_status_reg &&
		((operation_select_reg == OP_WRITE) || (operation_select_reg == OP_PAGE_ERASE));
	assign start_read = (state_reg == ST_IDLE) && !program_go_reg && read_go_reg &&
		read_permit_reg && (operation_select_reg == OP_READ);
	assign start_clear = (state_reg == ST_IDLE) && !program_go_reg && !read_go_reg &&
		buffer_clear_go_reg;

	always_comb begin
		if (operation_select_reg == OP_PAGE_ERASE) begin
			prog_len = program_time_select_reg ? TIMER_W'(ERASE_LONG) : TIMER_W'(ERASE_STD);
		end else begin
			prog_len = program_time_select_reg ? TIMER_W'(WRITE_LONG) : TIMER_W'(WRITE_STD);
		end
	end

	fiac_timer u_prog_timer (
		.core_clk(core_clk),
		.rst(rst),
		.load(start_prog),
		.abort(1'b0),
		.load_value(prog_len),
		.busy_reg(prog_busy),
		.expire_reg(prog_done)
	);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_prog) begin
					state_next = (operation_select_reg == OP_PAGE_ERASE) ? ST_ERASE : ST_WRITE;
				end else if (start_read) begin
					state_next = ST_READ;
				end else if (start_clear) begin
					state_next = ST_CLEAR;
				end
			end
			ST_ERASE: begin
				if (prog_done) begin
					state_next = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (prog_done) begin
					state_next = ST_CLEAR;
				end
			end
			ST_READ: begin
				if (flash_rd_valid) begin
					state_next = ST_IDLE;
				end
			end
			ST_CLEAR: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Operation control register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			unlock_status_reg <= 1'b0;
			operation_select_reg <= OP_WRITE;
			unlock_trigger_reg <= 1'b0;
			program_go_reg <= 1'b0;
			read_permit_reg <= 1'b0;
			read_go_reg <= 1'b0;
		end else begin
			if (unlock_set) begin
				unlock_status_reg <= 1'b1;
			end else if (wr_op && !reg_req.wdata[OPC_UNLOCK_STATUS]) begin
				unlock_status_reg <= 1'b0;
			end
			if (wr_op) begin
				operation_select_reg <= reg_req.wdata[OPC_SELECT_MSB:OPC_SELECT_LSB];
				read_permit_reg <= reg_req.wdata[OPC_READ_PERMIT];
			end
			if (unlock_expire) begin
				unlock_trigger_reg <= 1'b0;
			end else if (unlock_load) begin
				unlock_trigger_reg <= 1'b1;
			end
			if (wr_op && reg_req.wdata[OPC_PROGRAM_GO]) begin
				program_go_reg <= 1'b1;
			end else if (prog_done) begin
				program_go_reg <= 1'b0;
			end else if ((state_reg == ST_IDLE) && program_go_reg && !start_prog) begin
				program_go_reg <= 1'b0;
			end
			if (wr_op) begin
				read_go_reg <= reg_req.wdata[OPC_READ_GO] && reg_req.wdata[OPC_READ_PERMIT];
			end else if ((state_reg == ST_READ) && flash_rd_valid) begin
				read_go_reg <= 1'b0;
			end else if ((state_reg == ST_IDLE) && read_go_reg && !program_go_reg && !start_read) begin
				read_go_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Timing and buffer control, chip reset key
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			program_time_select_reg <= 1'b0;
			buffer_clear_go_reg <= 1'b0;
			chip_reset_key_reg <= BYTE_RESET;
			chip_reset_reg <= 1'b0;
		end else begin
			if (wr_tbc) begin
				program_time_select_reg <= reg_req.wdata[TBC_TIME_SELECT];
			end
			if (wr_tbc && reg_req.wdata[TBC_BUFFER_CLEAR]) begin
				buffer_clear_go_reg <= 1'b1;
			end else if ((state_reg == ST_CLEAR) && buffer_clear_go_reg) begin
				buffer_clear_go_reg <= 1'b0;
			end
			if (wr_key) begin
				chip_reset_key_reg <= reg_req.wdata;
			end
			chip_reset_reg <= wr_key && (reg_req.wdata == CHIP_RESET_PATTERN);
		end
	end

	// ----------------------------------------------------------------
	// Address register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			address_reg <= '0;
		end else begin
			if (reg_req.wr && (reg_req.index == IDX_ADDRESS_LOW)) begin
				address_reg[7:0] <= reg_req.wdata;
			end else if (reg_req.wr && (reg_req.index == IDX_ADDRESS_HIGH)) begin
				address_reg[ADDR_W-1:8] <= reg_req.wdata[ADDR_HIGH_W-1:0];
			end else if (wr_d0h && (address_reg[PAGE_OFS_W-1:0] != PAGE_LAST_WORD)) begin
				address_reg <= address_reg + ADDR_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_data
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					data_low_reg[gi] <= BYTE_RESET;
					data_high_reg[gi] <= BYTE_RESET;
				end else begin
					if (gi == 0 && state_reg == ST_READ && flash_rd_valid) begin
						data_low_reg[gi] <= flash_rd_data[7:0];
						data_high_reg[gi] <= flash_rd_data[15:8];
					end else if (reg_req.wr && reg_req.index == 4'(IDX_DATA0_LOW + 4'(2 * gi))) begin
						data_low_reg[gi] <= reg_req.wdata;
					end else if (reg_req.wr && reg_req.index == 4'(IDX_DATA0_HIGH + 4'(2 * gi))) begin
						data_high_reg[gi] <= reg_req.wdata;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Flash command outputs and processor stall
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flash_cmd_reg <= '0;
			cpu_stall_reg <= 1'b0;
		end else begin
			flash_cmd_reg.buf_load <= wr_d0h && unlock_status_reg;
			if (wr_d0h) begin
				flash_cmd_reg.buf_word <= address_reg[PAGE_OFS_W-1:0];
				flash_cmd_reg.buf_data <= {reg_req.wdata, data_low_reg[0]};
			end
			flash_cmd_reg.buf_clear <= (state_next == ST_CLEAR) && (state_reg != ST_CLEAR);
			flash_cmd_reg.erase <= (state_next == ST_ERASE);
			flash_cmd_reg.write <= (state_next == ST_WRITE);
			flash_cmd_reg.read <= (state_next == ST_READ) && read_permit_reg;
			flash_cmd_reg.addr <= address_reg;
			cpu_stall_reg <= (state_next == ST_ERASE) || (state_next == ST_WRITE) ||
				(state_next == ST_READ);
		end
	end

	// ----------------------------------------------------------------
	// Register read-back
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = BYTE_RESET;
		unique case (reg_req.index)
			IDX_OP_CONTROL: rd_mux = {unlock_status_reg, operation_select_reg, unlock_trigger_reg,
				program_go_reg, read_permit_reg, read_go_reg};
			IDX_CHIP_RESET_KEY: rd_mux = chip_reset_key_reg;
			IDX_TIMING_BUFFER: rd_mux = {UNUSED_TBC_ZERO, program_time_select_reg,
				buffer_clear_go_reg};
			IDX_ADDRESS_LOW: rd_mux = address_reg[7:0];
			IDX_ADDRESS_HIGH: rd_mux = {UNUSED_HIGH_ZERO, address_reg[ADDR_W-1:8]};
			IDX_DATA0_LOW: rd_mux = data_low_reg[0];
			IDX_DATA0_HIGH: rd_mux = data_high_reg[0];
			IDX_DATA1_LOW: rd_mux = data_low_reg[1];
			IDX_DATA1_HIGH: rd_mux = data_high_reg[1];
			IDX_DATA2_LOW: rd_mux = data_low_reg[2];
			IDX_DATA2_HIGH: rd_mux = data_high_reg[2];
			IDX_DATA3_LOW: rd_mux = data_low_reg[3];
			IDX_DATA3_HIGH: rd_mux = data_high_reg[3];
			default: rd_mux = BYTE_RESET;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_reg <= BYTE_RESET;
		end else if (reg_req.rd) begin
			reg_rdata_reg <= rd_mux;
		end
	end

endmodule

`default_nettype wire

//--- test/fiac_control_asserts.sv
/*
  Checker for the flash programming control block, bound to its top module.
  Assumes the shortened timing parameters of the testbench are handed on by the bind.
*/
`timescale 1ns/1ps
`default_nettype none

module fiac_control_asserts
	import fiac_pkg::*;
#(
	parameter int ERASE_STD = 20,
	parameter int WRITE_STD = 15,
	parameter int ERASE_LONG = 25,
	parameter int WRITE_LONG = 18,
	parameter int UNLOCK_LEN = 40
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire fiac_reg_req_type reg_req,
	input wire logic [7:0] reg_rdata_reg,
	// Flash side
	input wire fiac_flash_cmd_type flash_cmd_reg,
	input wire logic flash_rd_valid,
	input wire logic [15:0] flash_rd_data,
	// System
	input wire logic cpu_stall_reg,
	input wire logic chip_reset_reg
);
	// ------------------------------------------------------------
	// Helper decode
	// ------------------------------------------------------------
	logic wr_op;
	logic wr_key;
	logic wr_lo;
	logic wr_hi;
	logic busy;
	logic [TIMER_W-1:0] run_cnt;
	assign wr_op = reg_req.wr && reg_req.index == IDX_OP_CONTROL;
	assign wr_key = reg_req.wr && reg_req.index == IDX_CHIP_RESET_KEY && reg_req.wdata == CHIP_RESET_PATTERN;
	assign wr_lo = reg_req.wr && reg_req.index == IDX_DATA0_LOW;
	assign wr_hi = reg_req.wr && reg_req.index == IDX_DATA0_HIGH;
	assign busy = flash_cmd_reg.erase || flash_cmd_reg.write || flash_cmd_reg.read;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			run_cnt <= '0;
		end else if (flash_cmd_reg.erase || flash_cmd_reg.write) begin
			run_cnt <= run_cnt + 1'b1;
		end else begin
			run_cnt <= '0;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	chip_reset_a: assert property (wr_key |=> chip_reset_reg)
		else $error("chip reset pulse missing");
	reset_cause_a: assert property (chip_reset_reg |-> $past(wr_key))
		else $error("chip reset without key write");
	low_only_a: assert property (wr_lo |=> !flash_cmd_reg.buf_load)
		else $error("low byte write loaded buffer");
	load_word_a: assert property (flash_cmd_reg.buf_load |-> $past(wr_hi) && flash_cmd_reg.buf_data[15:8] == $past(reg_req.wdata))
		else $error("buffer load not from high byte write");
	high_zero_a: assert property (reg_req.rd && reg_req.index == IDX_ADDRESS_HIGH |=> reg_rdata_reg[7:5] == UNUSED_HIGH_ZERO)
		else $error("address high upper bits not zero");
	tbc_zero_a: assert property (reg_req.rd && reg_req.index == IDX_TIMING_BUFFER |=> reg_rdata_reg[7:2] == UNUSED_TBC_ZERO)
		else $error("timing register upper bits not zero");
	prog_start_a: assert property ($rose(flash_cmd_reg.erase || flash_cmd_reg.write) |-> $past(wr_op && reg_req.wdata[OPC_PROGRAM_GO], 2) || $past(wr_op && reg_req.wdata[OPC_PROGRAM_GO], 3))
		else $error("program started without go");
	read_start_a: assert property ($rose(flash_cmd_reg.read) |-> $past(wr_op && reg_req.wdata[OPC_READ_GO], 2) || $past(wr_op && reg_req.wdata[OPC_READ_GO], 3))
		else $error("read started without go");
	read_hold_a: assert property (flash_cmd_reg.read && !flash_rd_valid |=> flash_cmd_reg.read)
		else $error("read dropped before data");
	read_end_a: assert property (flash_cmd_reg.read && flash_rd_valid |-> ##[1:2] !flash_cmd_reg.read)
		else $error("read held after data");
	stall_hold_a: assert property (busy |-> cpu_stall_reg)
		else $error("core not stalled during operation");
	stall_cause_a: assert property ($rose(cpu_stall_reg) |-> busy)
		else $error("stall without operation");
	erase_len_a: assert property ($fell(flash_cmd_reg.erase) |-> run_cnt >= ERASE_STD - 1 && run_cnt <= ERASE_LONG + 2)
		else $error("erase duration out of range");
	write_len_a: assert property ($fell(flash_cmd_reg.write) |-> run_cnt >= WRITE_STD - 1 && run_cnt <= WRITE_LONG + 2)
		else $error("write duration out of range");
	buf_wipe_a: assert property ($fell(flash_cmd_reg.write) |-> ##[0:2] flash_cmd_reg.buf_clear)
		else $error("buffer not cleared after write");
endmodule

bind fiac_control fiac_control_asserts #(.ERASE_STD(ERASE_STD), .WRITE_STD(WRITE_STD), .ERASE_LONG(ERASE_LONG),
	.WRITE_LONG(WRITE_LONG), .UNLOCK_LEN(UNLOCK_LEN)) u_asserts (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
	.reg_rdata_reg(reg_rdata_reg), .flash_cmd_reg(flash_cmd_reg), .flash_rd_valid(flash_rd_valid),
	.flash_rd_data(flash_rd_data), .cpu_stall_reg(cpu_stall_reg), .chip_reset_reg(chip_reset_reg));

`default_nettype wire

//--- test/fiac_flash_model.sv
/*
  Behavioural flash array answering word reads after a set delay.
  Assumes the read request stays high until the valid pulse is seen.
*/
`timescale 1ns/1ps
`default_nettype none

module fiac_flash_model
	import fiac_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Command side
	input wire fiac_flash_cmd_type flash_cmd,
	input wire logic [3:0] delay,
	// Answer side
	output var logic rd_valid,
	output var logic [15:0] rd_data
);
	logic [3:0] cnt;
	logic done;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			done <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 16'h0000;
		end else begin
			rd_valid <= 1'b0;
			rd_data <= ~rd_data;
			if (!flash_cmd.read) begin
				cnt <= '0;
				done <= 1'b0;
			end else if (!done && cnt == delay) begin
				rd_valid <= 1'b1;
				done <= 1'b1;
				rd_data <= 16'ha5c3 ^ {3'h0, flash_cmd.addr};
			end else if (!done) begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

//--- test/tb_flash_iap_control.sv
/*
  Self-checking testbench for the flash programming control block.
  Assumes the checker is bound separately and a flash model answers reads.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_flash_iap_control
	import fiac_pkg::*;
;
	localparam int WSTD = 15;
	localparam int ELONG = 25;
	localparam int ULEN = 40;
	logic core_clk, rst, rd_valid, stall, chip_rst, rd_seen;
	fiac_reg_req_type reg_req;
	fiac_flash_cmd_type cmd;
	logic [7:0] rdata, lo, hi;
	logic [15:0] rd_word;
	logic [3:0] delay;
	logic [4:0] w;
	logic [7:0] rq[$];
	string rn[$];
	logic [20:0] bq[$];
	int bad_count, tests_run, n;
	integer seed = 87;

	fiac_control #(.ERASE_STD(20), .WRITE_STD(WSTD), .ERASE_LONG(ELONG), .WRITE_LONG(18), .UNLOCK_LEN(ULEN)) u_dut (
		.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata_reg(rdata), .flash_cmd_reg(cmd),
		.flash_rd_valid(rd_valid), .flash_rd_data(rd_word), .cpu_stall_reg(stall), .chip_reset_reg(chip_rst));
	fiac_flash_model u_flash (.core_clk(core_clk), .rst(rst), .flash_cmd(cmd), .delay(delay),
		.rd_valid(rd_valid), .rd_data(rd_word));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		@(negedge core_clk);
		reg_req = {1'b1, 1'b0, idx, d};
		@(negedge core_clk);
		reg_req = '0;
	endtask

	task automatic rd(input logic [3:0] idx, input logic [7:0] e, input string s);
		rq.push_back(e);
		rn.push_back(s);
		@(negedge core_clk);
		reg_req = {1'b0, 1'b1, idx, 8'h00};
		@(negedge core_clk);
		reg_req = '0;
	endtask

	task automatic run(output int k);
		int i;
		i = 0;
		k = 0;
		while (stall !== 1'b1 && i < 20) begin
			cyc(1);
			i++;
		end
		while (stall === 1'b1 && k < 1000) begin
			cyc(1);
			k++;
		end
	endtask

	task automatic prog(input logic [7:0] op, input logic [7:0] tb, input int len, input string s);
		int k;
		wr(IDX_TIMING_BUFFER, tb);
		wr(IDX_OP_CONTROL, op);
		run(k);
		check(s, 24'h1, {23'h0, k >= len - 1 && k <= len + 3});
		rd(IDX_OP_CONTROL, op & 8'hfb, s);
	endtask

	// ------------------------------------------------------------
	// Result watcher
	// ------------------------------------------------------------
	always @(posedge core_clk) rd_seen <= reg_req.rd;
	always @(negedge core_clk) begin
		if (rd_seen === 1'b1) check(rn.pop_front(), {16'h0, rq.pop_front()}, {16'h0, rdata});
		if (cmd.buf_load === 1'b1 && bq.size() == 0) check("buf_extra", 24'h0, 24'h1);
		else if (cmd.buf_load === 1'b1) check("buf_load", {3'h0, bq.pop_front()}, {3'h0, cmd.buf_word, cmd.buf_data});
	end

	initial begin
		#200000;
		bad_count++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		reg_req = '0;
		delay = 4'h0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		for (int i = 0; i < 14; i++) rd(i[3:0], 8'h00, "reset_value");
		for (int i = 7; i < 11; i++) begin
			lo = 8'($random(seed));
			wr(i[3:0], lo);
			rd(i[3:0], lo, "data_rw");
		end
		wr(IDX_ADDRESS_HIGH, 8'hff);
		rd(IDX_ADDRESS_HIGH, 8'h1f, "addr_high");
		wr(IDX_TIMING_BUFFER, 8'hfd);
		cyc(4);
		rd(IDX_TIMING_BUFFER, 8'h00, "buf_clear");
		wr(IDX_TIMING_BUFFER, 8'hfe);
		rd(IDX_TIMING_BUFFER, 8'h02, "time_select");
		wr(IDX_OP_CONTROL, 8'h80);
		rd(IDX_OP_CONTROL, 8'h00, "sw_unlock");
		wr(IDX_CHIP_RESET_KEY, 8'h55);
		check("chip_reset", 24'h1, {23'h0, chip_rst});
		rd(IDX_CHIP_RESET_KEY, 8'h55, "reset_key");
		$display("test registers done");
		wr(IDX_DATA3_HIGH, 8'h00);
		wr(IDX_OP_CONTROL, 8'h68);
		cyc(ULEN + 5);
		rd(IDX_OP_CONTROL, 8'h60, "bad_key");
		wr(IDX_OP_CONTROL, 8'h68);
		wr(IDX_DATA1_LOW, KEY1_LOW);
		wr(IDX_DATA2_LOW, KEY2_LOW);
		wr(IDX_DATA3_LOW, KEY3_LOW);
		wr(IDX_DATA1_HIGH, KEY1_HIGH);
		wr(IDX_DATA2_HIGH, KEY2_HIGH);
		wr(IDX_DATA3_HIGH, KEY3_HIGH);
		rd(IDX_OP_CONTROL, 8'he8, "unlocked");
		cyc(ULEN + 5);
		rd(IDX_OP_CONTROL, 8'he0, "trigger_clear");
		$display("test unlock done");
		wr(IDX_ADDRESS_LOW, 8'h3d);
		wr(IDX_ADDRESS_HIGH, 8'h00);
		wr(IDX_OP_CONTROL, 8'h80);
		for (int i = 0; i < 4; i++) begin
			{hi, lo} = 16'($random(seed));
			w = (i < 2) ? 5'h1d + 5'(i) : PAGE_LAST_WORD;
			bq.push_back({w, hi, lo});
			wr(IDX_DATA0_LOW, lo);
			wr(IDX_DATA0_HIGH, hi);
		end
		rd(IDX_ADDRESS_LOW, 8'h3f, "page_hold");
		prog(8'h84, 8'h00, WSTD, "write_time");
		prog(8'h94, 8'h02, ELONG, "erase_time");
		wr(IDX_OP_CONTROL, 8'h04);
		cyc(4);
		rd(IDX_OP_CONTROL, 8'h00, "locked_go");
		$display("test program done");
		wr(IDX_ADDRESS_LOW, 8'h47);
		wr(IDX_ADDRESS_HIGH, 8'h05);
		for (int d = 0; d < 12; d += 6) begin
			delay = 4'(d);
			wr(IDX_OP_CONTROL, 8'h32);
			wr(IDX_OP_CONTROL, 8'h33);
			run(n);
			rd(IDX_DATA0_LOW, 8'h84, "read_low");
			rd(IDX_DATA0_HIGH, 8'ha0, "read_high");
			rd(IDX_OP_CONTROL, 8'h32, "read_done");
		end
		wr(IDX_OP_CONTROL, 8'h30);
		wr(IDX_OP_CONTROL, 8'h31);
		cyc(4);
		rd(IDX_OP_CONTROL, 8'h30, "no_permit");
		wr(IDX_OP_CONTROL, 8'h13);
		cyc(4);
		rd(IDX_OP_CONTROL, 8'h12, "wrong_mode");
		$display("test read done");
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		rd(IDX_OP_CONTROL, 8'h00, "second_reset");
		cyc(4);
		$display("test reset done");
		stop_test();
	end
endmodule

`default_nettype wire
